// ### include/tcc_consts.svh
// constants of the timer counter core: register indices, field bits, resets
// assumes a 32-bit ahb-lite bus, one register per aligned word
`ifndef TCC_CONSTS_SVH
`define TCC_CONSTS_SVH
`define TCC_IDX_CTRL    8'h0e
`define TCC_IDX_CNT_HI  8'h0f
`define TCC_IDX_CNT_LO  8'h10
`define TCC_IDX_PER_HI  8'h11
`define TCC_IDX_PER_LO  8'h12
`define TCC_BIT_FLAG    7
`define TCC_BIT_IRQEN   6
`define TCC_BIT_HALT    5
`define TCC_BIT_CLEAR   4
`define TCC_DIV_EXT     3'h7
`define TCC_RST_DIV     3'h0
`define TCC_RST_PERIOD  16'hffff
`define TCC_RST_COUNT   16'h0000
`define TCC_PRESC_W     6
`endif

// ### include/tcc_pkg.sv
// types of the timer counter core
// assumes tcc_consts.svh supplies the numeric constants
package tcc_pkg;
    // latched ahb address phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] index;
    } tcc_addr_phase_type;
    // state of the flag clearing handshake
    typedef enum logic [1:0] {
        TCC_IDLE  = 2'b01,
        TCC_ARMED = 2'b10
    } tcc_clr_state_type;
endpackage : tcc_pkg

// ### verilog/tcc_timer.sv
// timer counter core: prescaler, 16-bit counter, period wrap, overflow flag
// assumes an ahb-lite master on hclk and a pin sampled synchronously to hclk
`timescale 1ns/1ns
`include "tcc_consts.svh"
module tcc_timer #(
    parameter int PRESC_W = `TCC_PRESC_W
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        ext_count_clock_pin,
    input  wire logic        wait_mode,
    output logic             overflow_irq,
    output logic             wake_request,
    output logic             capture_inhibit
);
    tcc_pkg::tcc_addr_phase_type ap;
    tcc_pkg::tcc_clr_state_type  clr_state;
    logic [15:0]        count;
    logic [15:0]        period;
    logic [7:0]         held_low;
    logic               held;
    logic               overflow_flag;
    logic               overflow_irq_enable;
    logic               counter_halt;
    logic [2:0]         clock_divider_select;
    logic               period_inhibit;
    logic [PRESC_W-1:0] presc;
    logic [PRESC_W:0]   tap;
    logic               ext_s1;
    logic               ext_s2;
    logic               ext_s3;
    logic               tick;
    logic               wrap;
    logic               wrap_d;
    logic               addr_take;
    logic [7:0]         addr_index;
    logic               addr_hit;
    logic               rd_ctrl;
    logic               rd_hi;
    logic               rd_lo;
    logic               wr_ctrl;
    logic               wr_per_hi;
    logic               wr_per_lo;
    logic               do_clear;
    logic               clr_zero_wr;
    logic [7:0]         next_rdata;
    logic [7:0]         ctrl_value;

    // every access finishes in its first data phase cycle, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // address decode; registers are closed while the cpu waits
    assign addr_index = haddr[9:2];
    assign addr_hit   = (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'b00);
    assign addr_take  = hsel && hready && htrans[1] && !wait_mode;

    // latch the address phase for the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap <= '0;
        end else if (hready) begin
            ap.valid <= addr_take && addr_hit;
            ap.write <= hwrite;
            ap.index <= addr_index;
        end
    end

    // read strobes act in the address phase, writes in the data phase
    assign rd_ctrl   = addr_take && addr_hit && !hwrite && addr_index == `TCC_IDX_CTRL;
    assign rd_hi     = addr_take && addr_hit && !hwrite && addr_index == `TCC_IDX_CNT_HI;
    assign rd_lo     = addr_take && addr_hit && !hwrite && addr_index == `TCC_IDX_CNT_LO;
    assign wr_ctrl   = ap.valid && ap.write && ap.index == `TCC_IDX_CTRL;
    assign wr_per_hi = ap.valid && ap.write && ap.index == `TCC_IDX_PER_HI;
    assign wr_per_lo = ap.valid && ap.write && ap.index == `TCC_IDX_PER_LO;
    assign do_clear  = wr_ctrl && hwdata[`TCC_BIT_CLEAR];

    // status byte view; clear bit and bit 3 always read zero
    assign ctrl_value = {overflow_flag, overflow_irq_enable, counter_halt,
                         1'b0, 1'b0, clock_divider_select};

    // read mux, sampled into hrdata so data comes from a flip-flop
    always_comb begin
        next_rdata = 8'h00;
        unique case (addr_index)
            `TCC_IDX_CTRL:   next_rdata = ctrl_value;
            `TCC_IDX_CNT_HI: next_rdata = count[15:8];
            `TCC_IDX_CNT_LO: next_rdata = held ? held_low : count[7:0];
            `TCC_IDX_PER_HI: next_rdata = period[15:8];
            `TCC_IDX_PER_LO: next_rdata = period[7:0];
            default:         next_rdata = 8'h00;
        endcase
    end

    // read data register; unmapped or closed reads return zero
    // a read refused in wait state still loads zero, so no stale byte leaks out
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hsel && hready && htrans[1] && !hwrite) begin
            hrdata <= (addr_take && addr_hit) ? {24'h00_0000, next_rdata} : 32'h0000_0000;
        end
    end

    // control fields written by software
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            overflow_irq_enable  <= 1'b0;
            counter_halt         <= 1'b1;
            clock_divider_select <= `TCC_RST_DIV;
        end else if (wr_ctrl) begin
            overflow_irq_enable  <= hwdata[`TCC_BIT_IRQEN];
            counter_halt         <= hwdata[`TCC_BIT_HALT];
            clock_divider_select <= hwdata[2:0];
        end
    end

    // period register; high write blocks flag setting until low write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            period         <= `TCC_RST_PERIOD;
            period_inhibit <= 1'b0;
        end else begin
            if (wr_per_hi) begin
                period[15:8]   <= hwdata[7:0];
                period_inhibit <= 1'b1;
            end
            if (wr_per_lo) begin
                period[7:0]    <= hwdata[7:0];
                period_inhibit <= 1'b0;
            end
        end
    end

    // free-running prescaler, reset by the clear bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            presc <= '0;
        end else if (do_clear) begin
            presc <= '0;
        end else begin
            presc <= presc + 1'b1;
        end
    end

    // tap n is high once every 2**n bus clocks
    assign tap[0] = 1'b1;
    genvar gi;
    generate
        for (gi = 1; gi <= PRESC_W; gi++) begin : g_tap
            assign tap[gi] = &presc[gi-1:0];
        end
    endgenerate

    // external pin synchroniser; only stage two and three feed the edge detect
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
        end else begin
            ext_s1 <= ext_count_clock_pin;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
        end
    end

    // count enable: code 7 uses pin edges, others a prescaler tap
    always_comb begin
        if (clock_divider_select == `TCC_DIV_EXT) begin
            tick = ext_s2 && !ext_s3;
        end else begin
            tick = tap[clock_divider_select];
        end
    end

    assign wrap = tick && !counter_halt && count == period;

    // counter; clear wins over counting, halt freezes it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= `TCC_RST_COUNT;
        end else if (do_clear) begin
            count <= `TCC_RST_COUNT;
        end else if (tick && !counter_halt) begin
            count <= wrap ? `TCC_RST_COUNT : count + 16'h0001;
        end
    end

    // flag sets the cycle after the counter lands on zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wrap_d <= 1'b0;
        end else begin
            wrap_d <= wrap && !do_clear && !period_inhibit;
        end
    end

    // a zero write to the flag bit, armed or not
    assign clr_zero_wr = wr_ctrl && !hwdata[`TCC_BIT_FLAG];

    // flag clear handshake: a new overflow disarms so the event is kept
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clr_state <= tcc_pkg::TCC_IDLE;
        end else if (wrap_d) begin
            clr_state <= tcc_pkg::TCC_IDLE;
        end else if (rd_ctrl && overflow_flag) begin
            clr_state <= tcc_pkg::TCC_ARMED;
        end else if (clr_zero_wr) begin
            clr_state <= tcc_pkg::TCC_IDLE;
        end
    end

    // overflow flag; set wins over clear and writing one does nothing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            overflow_flag <= 1'b0;
        end else if (wrap_d) begin
            overflow_flag <= 1'b1;
        end else if (clr_zero_wr && clr_state == tcc_pkg::TCC_ARMED) begin
            overflow_flag <= 1'b0;
        end
    end

    // low byte latch for coherent 16-bit reads
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            held     <= 1'b0;
            held_low <= 8'h00;
        end else if (rd_lo) begin
            held <= 1'b0;
        end else if (rd_hi && !held) begin
            held     <= 1'b1;
            held_low <= count[7:0];
        end else if (do_clear) begin
            held_low <= 8'h00;
        end
    end

    // request outputs; a held latch in a debug break is software's concern
    assign overflow_irq    = overflow_flag && overflow_irq_enable;
    assign wake_request    = overflow_irq && wait_mode;
    assign capture_inhibit = counter_halt;

    // named steps of the flag clearing sequence
    sequence s_arm;
        rd_ctrl && overflow_flag && !wrap_d;
    endsequence
    sequence s_zero_write;
        clr_zero_wr && clr_state == tcc_pkg::TCC_ARMED && !wrap_d;
    endsequence

    AST_WRAP_SETS_FLAG: assert property (@(posedge hclk) disable iff (!hresetn)
        wrap && !do_clear && !period_inhibit |=> ##1 overflow_flag)
        else $error("flag not set after wrap");
    AST_CLEAR_NEEDS_ARM: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(overflow_flag) |-> $past(clr_state) == tcc_pkg::TCC_ARMED)
        else $error("flag cleared without arming read");
    AST_ARM_THEN_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
        s_zero_write |=> !overflow_flag)
        else $error("armed zero write did not clear flag");
    AST_OVERFLOW_KEPT: assert property (@(posedge hclk) disable iff (!hresetn)
        wrap_d |=> overflow_flag ##1 (overflow_flag || $past(clr_zero_wr)))
        else $error("overflow lost");
    AST_ONE_WRITE_NOP: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_ctrl && hwdata[`TCC_BIT_FLAG] && !overflow_flag && !wrap_d |=> !overflow_flag)
        else $error("writing one set the flag");
    AST_IRQ: assert property (@(posedge hclk) disable iff (!hresetn)
        overflow_irq == (overflow_flag && overflow_irq_enable))
        else $error("irq mismatch");
    AST_HALT_HOLDS: assert property (@(posedge hclk) disable iff (!hresetn)
        counter_halt && !do_clear |=> $stable(count))
        else $error("counter moved while halted");
    AST_CLEAR_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
        do_clear |=> count == 16'h0000 && presc == '0)
        else $error("clear did not zero counter");
    AST_HALT_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
        do_clear && hwdata[`TCC_BIT_HALT] |=> (count == 16'h0000) [*2])
        else $error("halt with clear did not hold zero");
    AST_LATCH_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        held && !rd_lo && !do_clear |=> held && $stable(held_low))
        else $error("low byte latch changed");
    AST_INHIBIT: assert property (@(posedge hclk) disable iff (!hresetn)
        period_inhibit |=> !wrap_d)
        else $error("flag set while period write open");
    AST_CAPTURE_INH: assert property (@(posedge hclk) disable iff (!hresetn)
        capture_inhibit == counter_halt)
        else $error("capture inhibit wrong");

    // handshake steps: the arming read opens it, any overflow shuts it again
    // set must win over a clearing write, or an overflow request is lost
    AST_ARM: assert property (@(posedge hclk) disable iff (!hresetn)
        s_arm |=> clr_state == tcc_pkg::TCC_ARMED)
        else $error("status read with flag set did not arm");
    AST_DISARM: assert property (@(posedge hclk) disable iff (!hresetn)
        wrap_d |=> clr_state == tcc_pkg::TCC_IDLE)
        else $error("overflow did not disarm the clear");
    AST_SET_WINS: assert property (@(posedge hclk) disable iff (!hresetn)
        wrap_d && clr_zero_wr |=> overflow_flag)
        else $error("clearing write beat a new overflow");

    // control fields follow the write data
    AST_IRQEN_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_ctrl |=> overflow_irq_enable == $past(hwdata[`TCC_BIT_IRQEN]))
        else $error("irq enable not written");
    AST_HALT_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_ctrl |=> counter_halt == $past(hwdata[`TCC_BIT_HALT]))
        else $error("halt bit not written");
    AST_DIV_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_ctrl |=> clock_divider_select == $past(hwdata[2:0]))
        else $error("divider select not written");

    // counting, wrap and prescaler
    AST_RUN_COUNTS: assert property (@(posedge hclk) disable iff (!hresetn)
        tick && !counter_halt && !wrap && !do_clear |=> count == $past(count) + 16'h0001)
        else $error("counter did not step");
    AST_WRAP_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
        wrap && !do_clear |=> count == 16'h0000)
        else $error("counter did not restart at zero");
    AST_PRESC_RUNS: assert property (@(posedge hclk) disable iff (!hresetn)
        !do_clear |=> presc == PRESC_W'($past(presc) + 1'b1))
        else $error("prescaler did not advance");
    AST_DIV2_SPACING: assert property (@(posedge hclk) disable iff (!hresetn)
        clock_divider_select == 3'h1 && tick && !wr_ctrl |=> !tick)
        else $error("divide by two ticked twice in a row");
    AST_EXT_EDGE: assert property (@(posedge hclk) disable iff (!hresetn)
        clock_divider_select == `TCC_DIV_EXT && $rose(ext_s2) |-> tick)
        else $error("pin edge gave no tick");

    // reads: latch, release, closed bus, clear bit
    AST_HOLD_SET: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_hi && !held |=> held && held_low == $past(count[7:0]))
        else $error("high read did not latch low byte");
    AST_LOW_RELEASE: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_lo |=> !held)
        else $error("low read did not release latch");
    AST_CLEAR_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        do_clear && !rd_lo && !rd_hi |=> held_low == 8'h00)
        else $error("clear left a held low byte");
    AST_CLEAR_READS_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_ctrl |=> hrdata[`TCC_BIT_CLEAR] == 1'b0)
        else $error("clear bit read back as one");
    AST_WAIT_READ_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
        wait_mode && hsel && hready && htrans[1] && !hwrite |=> hrdata == 32'h0000_0000)
        else $error("read in wait state returned data");
    AST_WAKE: assert property (@(posedge hclk) disable iff (!hresetn)
        overflow_irq && wait_mode |-> wake_request)
        else $error("enabled request did not wake");

    // period writes open and close the flag inhibit
    AST_PERIOD_HI_INH: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_per_hi |=> period_inhibit)
        else $error("period high write did not inhibit");
    AST_PERIOD_LO_OPEN: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_per_lo |=> !period_inhibit && period[7:0] == $past(hwdata[7:0]))
        else $error("period low write did not land");

endmodule : tcc_timer

// ### verif/tcc_timer_tb.sv
// testbench of the timer counter core: ahb-lite tasks, pin stimulus, read monitor
// assumes tcc_timer is the only slave, so its hreadyout is fed back as hready
`timescale 1ns/1ns
`include "tcc_consts.svh"
module tcc_timer_tb;
    localparam logic [7:0] ctl = `TCC_IDX_CTRL;
    localparam logic [7:0] chi = `TCC_IDX_CNT_HI;
    localparam logic [7:0] clo = `TCC_IDX_CNT_LO;
    localparam logic [7:0] phi = `TCC_IDX_PER_HI;
    localparam logic [7:0] plo = `TCC_IDX_PER_LO;
    localparam logic [31:0] all = 32'hffff_ffff;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        ext_count_clock_pin;
    logic        wait_mode;
    logic        overflow_irq;
    logic        wake_request;
    logic        capture_inhibit;
    logic [63:0] note_q[$];
    logic [63:0] note;
    logic        read_phase;
    logic [15:0] ext_n;
    logic [7:0]  per_lo;
    int          failures;
    int          checked;

    tcc_timer i_tcc_timer (
        .hclk                (hclk),
        .hresetn             (hresetn),
        .hsel                (hsel),
        .haddr               (haddr),
        .htrans              (htrans),
        .hwrite              (hwrite),
        .hsize               (hsize),
        .hwdata              (hwdata),
        .hready              (hreadyout),
        .hreadyout           (hreadyout),
        .hrdata              (hrdata),
        .hresp               (hresp),
        .ext_count_clock_pin (ext_count_clock_pin),
        .wait_mode           (wait_mode),
        .overflow_irq        (overflow_irq),
        .wake_request        (wake_request),
        .capture_inhibit     (capture_inhibit)
    );

    // 125 mhz bus clock
    always #4 hclk = ~hclk;

    task give_verdict;
        if (failures == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict

    task compare(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : compare

    // bounded wait for hready; a hung slave ends the run as a failure
    task wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
            give_verdict();
        end
    endtask : wait_ready

    // one single transfer: address phase held until hready, then data phase
    task bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge hclk); // never raise what the last call lowered in one step
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr  <= {22'h00_0000, idx, 2'b00};
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
    endtask : bus

    // a read only leaves its expectation behind; the monitor compares it
    task rd(input logic [7:0] idx, input logic [31:0] exp, input logic [31:0] mask);
        note_q.push_back({mask, exp});
        bus(1'b0, idx, 32'h0000_0000);
    endtask : rd

    task wr(input logic [7:0] idx, input logic [7:0] data);
        bus(1'b1, idx, {24'h00_0000, data});
    endtask : wr

    // wide pulses so the synchroniser sees every rising edge of the pin
    task pulse(input int n);
        repeat (n) begin
            ext_count_clock_pin <= 1'b1;
            repeat (3) @(posedge hclk);
            ext_count_clock_pin <= 1'b0;
            repeat (3) @(posedge hclk);
        end
        repeat (4) @(posedge hclk);
    endtask : pulse

    task wait_irq;
        int n;
        n = 0;
        while (overflow_irq !== 1'b1 && n < 2000) begin
            @(posedge hclk);
            n++;
        end
        if (n >= 2000) begin
            failures++;
            give_verdict();
        end
    endtask : wait_irq

    // monitor: each completed read data phase takes the oldest note
    always @(posedge hclk) begin
        if (read_phase && hreadyout === 1'b1) begin
            if (note_q.size() == 0) begin
                failures++;
                $display("unexpected read at %0t: got %h expected %h", $time, hrdata, 32'h0);
            end else begin
                note = note_q.pop_front();
                compare(hrdata & note[63:32], note[31:0]);
                compare({31'h0000_0000, hresp}, 32'h0000_0000);
            end
        end
        if (hreadyout === 1'b1)
            read_phase <= hsel && htrans[1] && !hwrite;
    end

    // watchdog against a hang anywhere in the sequence
    initial begin
        repeat (100000) @(posedge hclk);
        failures++;
        give_verdict();
    end

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        ext_count_clock_pin = 1'b0;
        wait_mode = 1'b0;
        read_phase = 1'b0;
        failures = 0;
        checked = 0;
        void'($urandom(32'h2b11def1));
        ext_n = 16'h0100 | (16'($urandom) & 16'h007f);
        per_lo = 8'h03 + (8'($urandom) & 8'h07);
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        #1;
        compare({31'h0000_0000, capture_inhibit}, 32'h0000_0001);
        // reset values, read-only and unmapped places
        rd(ctl, 32'h0000_0020, all);
        rd(chi, 32'h0000_0000, all);
        rd(clo, 32'h0000_0000, all);
        rd(phi, 32'h0000_00ff, all);
        rd(plo, 32'h0000_00ff, all);
        wr(chi, 8'haa);
        wr(8'h20, 8'h55);
        rd(8'h20, 32'h0000_0000, all);
        repeat (20) @(posedge hclk);
        rd(chi, 32'h0000_0000, all);
        rd(clo, 32'h0000_0000, all);
        // external pin counting and the latched low byte
        wr(ctl, 8'h17);
        #1;
        compare({31'h0000_0000, capture_inhibit}, 32'h0000_0000);
        pulse(ext_n);
        rd(chi, 32'h0000_0001, all);
        pulse(5);
        rd(chi, 32'h0000_0001, all);
        rd(clo, {24'h00_0000, ext_n[7:0]}, all);
        rd(clo, {24'h00_0000, ext_n[7:0] + 8'h05}, all);
        // halt with clear stops at zero, other registers untouched
        wr(ctl, 8'h37);
        rd(chi, 32'h0000_0000, all);
        rd(clo, 32'h0000_0000, all);
        rd(plo, 32'h0000_00ff, all);
        rd(ctl, 32'h0000_0027, all);
        // each divider: about 18 counts in 18 divided periods (low bits ignored)
        for (int c = 0; c < 7; c++) begin
            wr(ctl, {5'h06, c[2:0]});
            wr(ctl, {5'h02, c[2:0]});
            repeat ((18 << c) - 2) @(posedge hclk);
            wr(ctl, {5'h04, c[2:0]});
            rd(clo, 32'h0000_0010, 32'h0000_00fc);
        end
        // short period, overflow, and a zero write after a later overflow
        wr(ctl, 8'h30);
        wr(phi, 8'h00);
        wr(plo, per_lo);
        rd(phi, 32'h0000_0000, all);
        rd(plo, {24'h00_0000, per_lo}, all);
        wr(ctl, 8'h50);
        wait_irq();
        rd(ctl, 32'h0000_00c0, 32'h0000_00f0);
        repeat (12) @(posedge hclk);
        wr(ctl, 8'h60);
        rd(ctl, 32'h0000_00e0, all);
        // armed clear, then a one written to the flag
        wr(ctl, 8'h60);
        rd(ctl, 32'h0000_0060, all);
        #1;
        compare({31'h0000_0000, overflow_irq}, 32'h0000_0000);
        wr(ctl, 8'he0);
        rd(ctl, 32'h0000_0060, all);
        // zero write without the arming read is refused
        wr(ctl, 8'h40);
        wait_irq();
        wr(ctl, 8'h60);
        rd(ctl, 32'h0000_00e0, all);
        // wait state: halt left clear, wake request, registers closed
        wr(ctl, 8'hc0);
        wait_mode <= 1'b1;
        @(posedge hclk);
        #1;
        compare({31'h0000_0000, wake_request}, 32'h0000_0001);
        rd(ctl, 32'h0000_0000, all);
        wr(ctl, 8'h00);
        wait_mode <= 1'b0;
        rd(ctl, 32'h0000_00c0, all);
        wr(ctl, 8'ha0);
        #1;
        compare({31'h0000_0000, overflow_irq}, 32'h0000_0000);
        compare({31'h0000_0000, wake_request}, 32'h0000_0000);
        rd(ctl, 32'h0000_00a0, all);
        // period high write holds off the flag until the low byte follows
        wr(ctl, 8'h20);
        wr(phi, 8'h00);
        wr(ctl, 8'h10);
        repeat (40) @(posedge hclk);
        rd(ctl, 32'h0000_0000, 32'h0000_0080);
        wr(plo, per_lo);
        repeat (30) @(posedge hclk);
        rd(ctl, 32'h0000_0080, 32'h0000_0080);
        repeat (3) @(posedge hclk);
        give_verdict();
    end
endmodule : tcc_timer_tb
